// ---- design/scg_pkg.sv ----
// Purpose: shared constants and types for the sample clock generator mode block
// Assumes: 20 MHz system clock, registers reached over a plain strobe port
// Notes: rates are carried in units of 1/7 Hz so the 8/7 modifiers stay exact
package scg_pkg;
   localparam int unsigned CLK_HZ = 20_000_000;
   localparam logic [7:0] MODE_ADDR = 8'h10;
   localparam logic [7:0] STATUS_ADDR = 8'h20;
   localparam logic [15:0] MODE_RESET = 16'h00ff;
   localparam logic [15:0] MODE_WRITE_MASK = 16'hfcff;
   localparam int REF_BIT = 15;
   localparam int VID_BIT = 14;
   localparam int GAIN_BIT = 13;
   localparam int P200_BIT = 12;
   localparam int X87_BIT = 11;
   localparam int C128_BIT = 10;
   localparam int unsigned BIT_STEP_HZ = 2400;
   localparam int unsigned PLUS_HZ = 200;
   localparam int unsigned HZ_UNITS = 7;
   localparam int unsigned CONV_PIN_MULT = 128;
   localparam logic [3:0] NIBBLE_SPECIAL = 4'hf;
   localparam logic [3:0] BIT_CODE_MAX = 4'hb;
   localparam logic [3:0] DIV_CODE_MAX = 4'h7;
   // increment per 1/7 Hz for a 48-bit scaled accumulator step
   localparam longint unsigned NCO_K7 = (64'h1 << 48) / (64'(CLK_HZ) * HZ_UNITS);

   typedef struct packed {
      logic reference_select;
      logic video_lock_enable;
      logic loop_gain_select;
      logic bit_rate_plus_two_hundred;
      logic eight_sevenths_modifier;
      logic conv_pin_times_128;
      logic [1:0] reserved;
      logic [3:0] conversion_rate_nibble;
      logic [3:0] bit_rate_or_divisor_nibble;
   } scg_mode_t;

   typedef enum {SCG_XTAL, SCG_SYNC_NORMAL, SCG_VIDEO} scg_src_t;
endpackage

// ---- design/scg_mode_ctrl.sv ----
// Purpose: mode register and clock synthesis for the first sample clock generator
// Assumes: external pins arrive asynchronously; rate register value comes from logic on clk
// Notes: clocks are numerically controlled oscillators on clk; the analog loop is not modelled
`timescale 1ns/1ps
`default_nettype none
module scg_mode_ctrl (
   input wire logic clk,
   input wire logic srst,
   input wire logic [7:0] addr,
   input wire logic [15:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [15:0] rdata,
   input wire logic reset_pin_n,
   input wire logic powerdown_pin_n,
   input wire logic sync_reference_input,
   input wire logic [15:0] rate_value,
   output logic conversion_clock_output,
   output logic bit_clock_output,
   output logic loop_gain_select,
   output logic phase_shift_allow,
   output logic sync_locked_mode
);
   scg_pkg::scg_mode_t mode;
   scg_pkg::scg_src_t src;
   logic rst_s1, rst_s2, pd_s1, pd_s2, sync_s1, sync_s2, sync_s3;
   logic clear_active, sync_rise;
   logic [63:0] named7, actual7, bit_hz7, bit7, fast_inc, bit_inc;
   logic bit_enable, bit_is_fast;
   logic [31:0] fast_acc, bit_acc;
   logic fast_msb;
   logic [6:0] conv_div;

   // pins and sync come from outside clk; two flops before any use
   always_ff @(posedge clk) begin
      if (srst) begin
         rst_s1 <= 1'b0;
         rst_s2 <= 1'b0;
         pd_s1 <= 1'b0;
         pd_s2 <= 1'b0;
         sync_s1 <= 1'b0;
         sync_s2 <= 1'b0;
         sync_s3 <= 1'b0;
      end else begin
         rst_s1 <= reset_pin_n;
         rst_s2 <= rst_s1;
         pd_s1 <= powerdown_pin_n;
         pd_s2 <= pd_s1;
         sync_s1 <= sync_reference_input;
         sync_s2 <= sync_s1;
         sync_s3 <= sync_s2;
      end
   end

   assign clear_active = !rst_s2 || !pd_s2;
   assign sync_rise = sync_s2 && !sync_s3;

   // mode register; reserved bits are dropped so they read as zero
   always_ff @(posedge clk) begin
      if (srst || clear_active) begin
         mode <= scg_pkg::MODE_RESET;
      end else if (wr && addr == scg_pkg::MODE_ADDR) begin
         mode <= wdata & scg_pkg::MODE_WRITE_MASK;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         rdata <= 16'h0000;
      end else if (rd && addr == scg_pkg::MODE_ADDR) begin
         rdata <= mode;
      end else if (rd && addr == scg_pkg::STATUS_ADDR) begin
         rdata <= {10'h000, clear_active, sync_s2, bit_enable, sync_locked_mode,
                   bit_clock_output, conversion_clock_output};
      end else begin
         rdata <= 16'h0000;
      end
   end

   always_comb begin
      if (!mode.reference_select) begin
         src = scg_pkg::SCG_XTAL;
      end else if (mode.video_lock_enable) begin
         src = scg_pkg::SCG_VIDEO;
      end else begin
         src = scg_pkg::SCG_SYNC_NORMAL;
      end
   end

   assign loop_gain_select = mode.loop_gain_select;
   assign phase_shift_allow = !mode.reference_select;
   assign sync_locked_mode = mode.reference_select;

   // named conversion rate of the high nibble, in 1/7 Hz
   function automatic logic [63:0] named_rate7(input logic [3:0] code);
      case (code)
         4'h0: named_rate7 = 64'd50400;
         4'h1: named_rate7 = 64'd58800;
         4'h2: named_rate7 = 64'd63000;
         4'h3: named_rate7 = 64'd67200;
         4'h4: named_rate7 = 64'd78400;
         4'h5: named_rate7 = 64'd84000;
         4'h6: named_rate7 = 64'd89600;
         4'h7: named_rate7 = 64'd57600;
         4'h8: named_rate7 = 64'd72000;
         4'h9: named_rate7 = 64'd76800;
         4'ha: named_rate7 = 64'd96000;
         default: named_rate7 = 64'd0;
      endcase
   endfunction

   // video base rate in 1/7 Hz; pal drops codes above 3
   function automatic logic [63:0] base_rate7(input logic pal, input logic [2:0] code);
      case (code)
         3'h0: base_rate7 = 64'd336000;
         3'h1: base_rate7 = 64'd224000;
         3'h2: base_rate7 = 64'd308700;
         3'h3: base_rate7 = 64'd205800;
         3'h4: base_rate7 = pal ? 64'd0 : 64'd336000;
         3'h5: base_rate7 = pal ? 64'd0 : 64'd308392;
         default: base_rate7 = 64'd0;
      endcase
   endfunction

   always_comb begin
      named7 = named_rate7(mode.conversion_rate_nibble);
      case (src)
         scg_pkg::SCG_XTAL: begin
            // 8/7 stays exact because units are 1/7 Hz
            actual7 = mode.eight_sevenths_modifier ? 64'(rate_value) * 64'd8
                                                   : 64'(rate_value) * 64'(scg_pkg::HZ_UNITS);
         end
         scg_pkg::SCG_SYNC_NORMAL: actual7 = named7;
         scg_pkg::SCG_VIDEO: begin
            if (mode.bit_rate_or_divisor_nibble > scg_pkg::DIV_CODE_MAX) begin
               actual7 = 64'd0;
            end else begin
               actual7 = base_rate7(mode.conversion_rate_nibble[3],
                                    mode.conversion_rate_nibble[2:0])
                         / (64'(mode.bit_rate_or_divisor_nibble) + 64'd1);
            end
         end
         default: actual7 = 64'd0;
      endcase
   end

   always_comb begin
      bit_is_fast = (mode.conversion_rate_nibble == scg_pkg::NIBBLE_SPECIAL)
                 && (mode.bit_rate_or_divisor_nibble == scg_pkg::NIBBLE_SPECIAL);
      bit_enable = (src != scg_pkg::SCG_VIDEO)
                && (bit_is_fast || (mode.bit_rate_or_divisor_nibble <= scg_pkg::BIT_CODE_MAX
                                    && named7 != 64'd0));
      bit_hz7 = (64'(mode.bit_rate_or_divisor_nibble) + 64'd1)
                * 64'(scg_pkg::BIT_STEP_HZ) * 64'(scg_pkg::HZ_UNITS);
      if (mode.bit_rate_plus_two_hundred) begin
         bit_hz7 = bit_hz7 + 64'(scg_pkg::PLUS_HZ) * 64'(scg_pkg::HZ_UNITS);
      end
      // scale by actual over named conversion rate
      bit7 = (named7 == 64'd0) ? 64'd0 : (bit_hz7 * actual7) / named7;
      fast_inc = (actual7 * 64'(scg_pkg::CONV_PIN_MULT) * scg_pkg::NCO_K7) >> 16;
      bit_inc = (bit7 * scg_pkg::NCO_K7) >> 16;
   end

   // fast oscillator runs at 128x the conversion rate
   always_ff @(posedge clk) begin
      if (srst) begin
         fast_acc <= 32'h0000_0000;
         fast_msb <= 1'b0;
      end else begin
         fast_acc <= fast_acc + fast_inc[31:0];
         fast_msb <= fast_acc[31];
      end
   end

   // in normal sync mode only, sync edges realign the divider so the conversion phase follows the sync
   always_ff @(posedge clk) begin
      if (srst) begin
         conv_div <= 7'h00;
      end else if (src == scg_pkg::SCG_SYNC_NORMAL && sync_rise) begin
         conv_div <= 7'h00;
      end else if (fast_acc[31] && !fast_msb) begin
         conv_div <= conv_div + 7'h01;
      end
   end

   // both clock outputs are flops on clk, so no pulse is ever shorter than one period
   always_ff @(posedge clk) begin
      if (srst) begin
         conversion_clock_output <= 1'b0;
      end else if (mode.conv_pin_times_128) begin
         conversion_clock_output <= fast_acc[31];
      end else begin
         conversion_clock_output <= conv_div[6];
      end
   end

   always_ff @(posedge clk) begin
      if (srst || !bit_enable) begin
         bit_acc <= 32'h0000_0000;
         bit_clock_output <= 1'b0;
      end else if (bit_is_fast) begin
         bit_acc <= 32'h0000_0000;
         bit_clock_output <= fast_acc[31];
      end else begin
         bit_acc <= bit_acc + bit_inc[31:0];
         bit_clock_output <= bit_acc[31];
      end
   end

   mode_clear_a: assert property (@(posedge clk) disable iff (srst)
      clear_active |=> mode == scg_pkg::MODE_RESET)
      else $error("mode not held at default while pins low");

   write_refused_a: assert property (@(posedge clk) disable iff (srst)
      (clear_active && wr && addr == scg_pkg::MODE_ADDR) |=> mode == scg_pkg::MODE_RESET)
      else $error("mode accepted a write during clear");

   video_ignored_a: assert property (@(posedge clk) disable iff (srst)
      !mode.reference_select |-> src == scg_pkg::SCG_XTAL)
      else $error("video lock honoured with master clock reference");

   video_nobit_a: assert property (@(posedge clk) disable iff (srst)
      src == scg_pkg::SCG_VIDEO |=> !bit_clock_output)
      else $error("bit clock produced in video lock");

   phase_allow_a: assert property (@(posedge clk) disable iff (srst)
      phase_shift_allow != mode.reference_select)
      else $error("phase shift permission wrong for reference");

   rate_ignored_a: assert property (@(posedge clk) disable iff (srst)
      (mode.reference_select && $stable(mode)) |-> $stable(fast_inc))
      else $error("rate or 8/7 bit moved conversion under sync reference");

   gain_follow_a: assert property (@(posedge clk) disable iff (srst)
      $rose(mode.loop_gain_select) |-> loop_gain_select ##1 $stable(loop_gain_select))
      else $error("loop gain select does not follow mode");

   sync_lock_a: assert property (@(posedge clk) disable iff (srst)
      (src == scg_pkg::SCG_SYNC_NORMAL && sync_rise) |=> conv_div == 7'h00)
      else $error("conversion phase not realigned to sync");

   conv_pin_a: assert property (@(posedge clk) disable iff (srst)
      (!mode.conv_pin_times_128 && $past(!mode.conv_pin_times_128))
      |-> conversion_clock_output == $past(conv_div[6]))
      else $error("conversion pin not at conversion rate");

   bit_fast_a: assert property (@(posedge clk) disable iff (srst)
      $past(bit_is_fast && bit_enable) |-> bit_clock_output == fast_msb)
      else $error("bit clock not at 128x conversion rate");

   video_entry_c: cover property (@(posedge clk) disable iff (srst)
      src == scg_pkg::SCG_XTAL ##1 src == scg_pkg::SCG_VIDEO);
   sync_edge_c: cover property (@(posedge clk) disable iff (srst)
      src == scg_pkg::SCG_SYNC_NORMAL && sync_rise);
   conv_fast_c: cover property (@(posedge clk) disable iff (srst)
      mode.conv_pin_times_128 && $rose(conversion_clock_output));
   pin_clear_c: cover property (@(posedge clk) disable iff (srst)
      $rose(clear_active));
endmodule // scg_mode_ctrl
`default_nettype wire

// ---- tb/scg_sync_src.sv ----
// Purpose: far-side sync source feeding the line-rate reference pin
// Assumes: 20 MHz clk, line period rounded to whole clk cycles
// Notes: pulse is 64 cycles wide; no faulty behaviour is needed by any scenario
`timescale 1ns/1ps
`default_nettype none
module scg_sync_src (
   input wire logic clk,
   input wire logic srst,
   input wire logic pal,
   output logic sync_reference_input
);
   int cnt;
   int per;
   // nominal line rates, not the raised 15.750 kHz, so base code 4 stays nominal
   always_comb per = pal ? 1280 : 1271;
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt <= 0;
         sync_reference_input <= 1'b0;
      end else begin
         cnt <= (cnt >= per - 1) ? 0 : cnt + 1;
         sync_reference_input <= (cnt < 64);
      end
   end
endmodule // scg_sync_src
`default_nettype wire

// ---- tb/sample_clock_generator_mode_tb_top.sv ----
// Purpose: self-checking bench for the sample clock generator mode block
// Assumes: 20 MHz clk, mode register at 0x10, reserved bits masked on write
// Notes: pin rates are judged by timing whole periods, so NCO jitter averages out
`timescale 1ns/1ps
`default_nettype none
module sample_clock_generator_mode_tb_top;
   logic clk, srst, wr, rd, reset_pin_n, powerdown_pin_n, pal;
   logic [7:0] addr;
   logic [15:0] wdata, rdata, rate_value, d;
   logic sync_reference_input, conversion_clock_output, bit_clock_output;
   logic loop_gain_select, phase_shift_allow, sync_locked_mode;
   int fail_count, n_tests, seed, cnt;
   real named [11] = '{7200.0, 8400.0, 9000.0, 9600.0, 11200.0, 12000.0, 12800.0,
      7200.0 * 8 / 7, 9000.0 * 8 / 7, 9600.0 * 8 / 7, 12000.0 * 8 / 7};
   real vbase [6] = '{48000.0, 32000.0, 44100.0, 29400.0, 48000.0, 44056.0};
   logic [15:0] tm [14] = '{16'h003b, 16'h403b, 16'h103b, 16'h0870, 16'h00ff, 16'h8832,
      16'h043b, 16'hc400, 16'hc411, 16'hc422, 16'hc433, 16'hc446, 16'hc455, 16'hc4b4};
   logic [15:0] tr [14] = '{16'h2580, 16'h2580, 16'h2580, 16'h20d0, 16'h2580, 16'h1388,
      16'h2580, 16'h2580, 16'h2580, 16'h2580, 16'h2580, 16'h2580, 16'h2580, 16'h2580};
   logic [13:0] tsel = 14'h003f;

   scg_mode_ctrl dut (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
      .rdata(rdata), .reset_pin_n(reset_pin_n), .powerdown_pin_n(powerdown_pin_n),
      .sync_reference_input(sync_reference_input), .rate_value(rate_value),
      .conversion_clock_output(conversion_clock_output), .bit_clock_output(bit_clock_output),
      .loop_gain_select(loop_gain_select), .phase_shift_allow(phase_shift_allow),
      .sync_locked_mode(sync_locked_mode));
   scg_sync_src sync_src (.clk(clk), .srst(srst), .pal(pal),
      .sync_reference_input(sync_reference_input));

   function automatic real act_hz(input logic [15:0] m, input logic [15:0] r);
      if (m[15] && m[14]) return vbase[m[6:4]] / (real'(m[3:0]) + 1.0);
      if (m[15]) return named[m[7:4]];
      return r * (m[11] ? 8.0 / 7.0 : 1.0);
   endfunction

   function automatic real pin_hz(input logic [15:0] m, input logic [15:0] r, input logic sel);
      real a;
      a = act_hz(m, r);
      if (!sel) return m[10] ? a * 128.0 : a;
      if (m[7:0] == 8'hff) return a * 128.0;
      return (2400.0 * (real'(m[3:0]) + 1.0) + (m[12] ? 200.0 : 0.0)) * a / named[m[7:4]];
   endfunction

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_tests++;
      if (g !== e) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chkp(input string nm, input real e, input int g);
      n_tests++;
      if (g < e - 3.0 || g > e + 3.0) begin
         fail_count++;
         $display("MISMATCH %s expected %0.1f seen %0d", nm, e, g);
      end
   endtask

   task automatic wr_reg(input logic [7:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic rd_reg(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask

   task automatic chk_mode(input logic [15:0] e);
      rd_reg(scg_pkg::MODE_ADDR, d);
      chk16("mode", e, d);
      chk16("gain", {15'h0000, e[13]}, {15'h0000, loop_gain_select});
      chk16("locked", {15'h0000, e[15]}, {15'h0000, sync_locked_mode});
      chk16("phase", {15'h0000, !e[15]}, {15'h0000, phase_shift_allow});
   endtask

   // times n whole periods from one rising edge, n chosen so the span exceeds 1000 cycles
   task automatic meas(input logic sel, input real hz);
      int n, t, g, k;
      logic p, c;
      real e;
      n = 1 + int'(1000.0 * hz / scg_pkg::CLK_HZ);
      e = n * real'(scg_pkg::CLK_HZ) / hz;
      k = -1;
      t = 0;
      g = 0;
      p = sel ? bit_clock_output : conversion_clock_output;
      while (k < n && g < 40000) begin
         @(posedge clk);
         #1 c = sel ? bit_clock_output : conversion_clock_output;
         t++;
         g++;
         if (c === 1'b1 && p === 1'b0) begin
            if (k < 0) t = 0;
            k++;
         end
         p = c;
      end
      if (k < n) begin
         fail_count++;
         $display("MISMATCH clock edges expected %0d seen %0d", n, k);
         complete_run();
      end else begin
         chkp(sel ? "bit period" : "conv period", e, t);
      end
   endtask

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   initial begin
      srst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 16'h0000;
      rate_value = 16'h2580;
      reset_pin_n = 1'b1;
      powerdown_pin_n = 1'b1;
      pal = 1'b0;
      seed = 55996;
      fail_count = 0;
      n_tests = 0;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      repeat (5) @(posedge clk);
      chk_mode(scg_pkg::MODE_RESET);
      $display("test reset done");
      repeat (12) begin
         d = 16'($random(seed)) & scg_pkg::MODE_WRITE_MASK;
         rate_value <= 16'($random(seed));
         wr_reg(scg_pkg::MODE_ADDR, d);
         chk_mode(d);
      end
      wr_reg(8'h30, 16'h1234);
      rd_reg(8'h30, d);
      chk16("unmapped", 16'h0000, d);
      $display("test registers done");
      for (int i = 0; i < 2; i++) begin
         wr_reg(scg_pkg::MODE_ADDR, 16'h8000);
         if (i == 0) reset_pin_n <= 1'b0;
         else powerdown_pin_n <= 1'b0;
         repeat (4) @(posedge clk);
         wr_reg(scg_pkg::MODE_ADDR, 16'h1234);
         chk_mode(scg_pkg::MODE_RESET);
         reset_pin_n <= 1'b1;
         powerdown_pin_n <= 1'b1;
         repeat (4) @(posedge clk);
         chk_mode(scg_pkg::MODE_RESET);
      end
      $display("test clear pins done");
      for (int i = 0; i < 14; i++) begin
         pal <= tm[i][7];
         rate_value <= tr[i];
         wr_reg(scg_pkg::MODE_ADDR, tm[i]);
         meas(tsel[i], pin_hz(tm[i], tr[i], tsel[i]));
         if (tm[i][15:14] == 2'b11) begin
            cnt = 0;
            repeat (2000) begin
               @(posedge clk);
               #1 if (bit_clock_output !== 1'b0) cnt++;
            end
            chk16("bit idle", 16'h0000, cnt[15:0]);
         end
      end
      $display("test frequencies done");
      complete_run();
   end
endmodule // sample_clock_generator_mode_tb_top
`default_nettype wire
